// ===== verilog/dtcu_pkg.sv
// dtcu_pkg: constants and state layout shared by the dual timer/counter block.
// assumes a 32-bit AHB-Lite register port and a 100 MHz system clock.
package dtcu_pkg;
  // register byte addresses (printed offsets are word indices, byte address = 4 x index)
  localparam logic [7:0]  IDX_TIMER_CONTROL   = 8'h88;
  localparam logic [7:0]  IDX_TIMER_MODE      = 8'h89;
  localparam logic [7:0]  IDX_TIMER0_LOW      = 8'h8A;
  localparam logic [7:0]  IDX_TIMER1_LOW      = 8'h8B;
  localparam logic [7:0]  IDX_TIMER0_HIGH     = 8'h8C;
  localparam logic [7:0]  IDX_TIMER1_HIGH     = 8'h8D;
  localparam logic [7:0]  IDX_PRESCALE_CTRL   = 8'h8E;
  localparam logic [7:0]  IDX_IRQ_STATUS      = 8'h90;
  localparam logic [7:0]  IDX_IRQ_CLEAR       = 8'h91;
  localparam logic [7:0]  IDX_IRQ_ENABLE      = 8'h92;
  localparam logic [7:0]  IDX_ISR_ENTRY       = 8'h93;
  localparam logic [11:0] ADDR_TIMER_CONTROL  = {2'h0, IDX_TIMER_CONTROL, 2'h0};
  localparam logic [11:0] ADDR_TIMER_MODE     = {2'h0, IDX_TIMER_MODE, 2'h0};
  localparam logic [11:0] ADDR_TIMER0_LOW     = {2'h0, IDX_TIMER0_LOW, 2'h0};
  localparam logic [11:0] ADDR_TIMER1_LOW     = {2'h0, IDX_TIMER1_LOW, 2'h0};
  localparam logic [11:0] ADDR_TIMER0_HIGH    = {2'h0, IDX_TIMER0_HIGH, 2'h0};
  localparam logic [11:0] ADDR_TIMER1_HIGH    = {2'h0, IDX_TIMER1_HIGH, 2'h0};
  localparam logic [11:0] ADDR_PRESCALE_CTRL  = {2'h0, IDX_PRESCALE_CTRL, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STATUS     = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [11:0] ADDR_IRQ_CLEAR      = {2'h0, IDX_IRQ_CLEAR, 2'h0};
  localparam logic [11:0] ADDR_IRQ_ENABLE     = {2'h0, IDX_IRQ_ENABLE, 2'h0};
  localparam logic [11:0] ADDR_ISR_ENTRY      = {2'h0, IDX_ISR_ENTRY, 2'h0};

  // timer_control bit positions
  localparam int BIT_T1_OVERFLOW   = 7;
  localparam int BIT_T1_RUN        = 6;
  localparam int BIT_T0_OVERFLOW   = 5;
  localparam int BIT_T0_RUN        = 4;
  // timer_mode field positions (timer 0 low nibble, timer 1 high nibble)
  localparam int BIT_T0_MODE_LO    = 0;
  localparam int BIT_T0_COUNT_SEL  = 2;
  localparam int BIT_T0_GATE       = 3;
  localparam int BIT_T1_MODE_LO    = 4;
  localparam int BIT_T1_COUNT_SEL  = 6;
  localparam int BIT_T1_GATE       = 7;
  // clock_prescale_control bit positions
  localparam int BIT_T0_PRESCALE   = 3;
  localparam int BIT_T1_PRESCALE   = 4;
  localparam int BIT_T2_PRESCALE   = 5;

  localparam logic [7:0] RST_TIMER_CONTROL  = 8'h00;
  localparam logic [7:0] RST_TIMER_MODE     = 8'h00;
  localparam logic [7:0] RST_TIMER_BYTE     = 8'h00;
  localparam logic [7:0] RST_PRESCALE_CTRL  = 8'hC7;

  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;

  typedef enum logic [1:0] {
    DTCU_MODE13,
    DTCU_MODE16,
    DTCU_RELOAD8,
    DTCU_SPLIT8
  } dtcu_mode_e;

  typedef enum logic [1:0] {
    DTCU_BUS_IDLE,
    DTCU_BUS_WRITE,
    DTCU_BUS_READ
  } dtcu_bus_e;

  typedef struct packed {
    dtcu_bus_e   busPhase;
    logic [11:0] busAddr;
    logic [31:0] rdata;
    logic [7:0]  control;
    logic [7:0]  mode;
    logic [7:0]  t0Low;
    logic [7:0]  t0High;
    logic [7:0]  t1Low;
    logic [7:0]  t1High;
    logic [7:0]  prescale;
    logic [3:0]  div0;
    logic [3:0]  div1;
    logic [2:0]  pin0Sync;
    logic [2:0]  pin1Sync;
    logic [2:0]  gate0Sync;
    logic [2:0]  gate1Sync;
    logic        gate0Stable;
    logic        gate1Stable;
    logic        pin0Stable;
    logic        pin1Stable;
    logic        t1Tick;
    logic [1:0]  irqStatus;
    logic [1:0]  irqEnable;
    logic        irq;
  } dtcu_state_s;
endpackage : dtcu_pkg

// ===== verilog/dtcu_timer_unit.sv
// dtcu_timer_unit: two timer/counters with an AHB-Lite register slave.
// assumes count and gate pins are asynchronous to clk; single word AHB-Lite transfers.
// Summary of operation
// - timer mode with default prescale advances once every twelve clocks.
// - per-timer prescale bit: one divides clock by four, zero by twelve.
// - counter mode increments on falling edge of count pin, sampled each clock.
// - overflow flag cleared by hardware at interrupt entry, or by software.
// - run bit enables counting; clearing it halts while keeping the count.
// - gate bit makes the external gate pin an extra counting condition.
// - count select bit picks external count pin or internal prescaled clock.
// - mode 0: low byte 5-bit prescaler feeds high byte, 13 bits total.
// - mode 1: high and low bytes form one 16-bit counter.
// - mode 2: low byte 8-bit counter reloaded from high byte.
// - mode 3 only for timer 0; low byte is independent 8-bit counter.
// - in timer 0 mode 3 high byte is separate timer under timer 1 control.
// - mode 2 reload happens at the moment the low byte overflows.
// - mode 3 low byte uses timer 0 run/flag; high byte timer 1's.
`timescale 1ns/1ps
`default_nettype none
module dtcu_timer_unit
  import dtcu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        t0CountPin,
  input  wire logic        t1CountPin,
  input  wire logic        t0GatePin,
  input  wire logic        t1GatePin,
  output logic             irq,
  output logic             t1OverflowPulse
);
  import dtcu_pkg::*;

  dtcu_state_s cur_ff;
  dtcu_state_s nxt_st;
  logic        nxt_t1Tick;

  // terminal count for the chosen prescale: 4 or 12 clocks per tick
  function automatic logic [3:0] divTop(input logic fast);
    divTop = fast ? (DIV_FAST - 4'h1) : (DIV_SLOW - 4'h1);
  endfunction

  // run qualified by gate: run && (!gate || pin)
  function automatic logic runGate(input logic run, input logic gateEn, input logic pin);
    runGate = run && (!gateEn || pin);
  endfunction

  logic       addrPhase;
  logic       divTick0;
  logic       divTick1;
  logic       fall0;
  logic       fall1;
  logic       gate0Lvl;
  logic       gate1Lvl;
  logic       en0;
  logic       en1;
  logic       inc0;
  logic       inc1;
  logic       incSplitHi;
  logic       ovf0;
  logic       ovf1;
  logic       t1Idle;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic [8:0] sumLo;
  logic [8:0] sumHi;
  logic [8:0] sumLo1;
  logic [8:0] sumHi1;
  logic [1:0] isrEntry;
  logic [7:0] wbyte;

  always_comb
  begin
    nxt_st     = cur_ff;
    nxt_t1Tick = 1'b0;
    addrPhase  = hsel && htrans[1] && hready;
    wbyte      = hwdata[7:0];
    isrEntry   = 2'b00;
    mode0      = cur_ff.mode[BIT_T0_MODE_LO +: 2];
    mode1      = cur_ff.mode[BIT_T1_MODE_LO +: 2];

    // pin synchronisers; a change counts once stages two and three agree
    nxt_st.pin0Sync  = {cur_ff.pin0Sync[1:0], t0CountPin};
    nxt_st.pin1Sync  = {cur_ff.pin1Sync[1:0], t1CountPin};
    nxt_st.gate0Sync = {cur_ff.gate0Sync[1:0], t0GatePin};
    nxt_st.gate1Sync = {cur_ff.gate1Sync[1:0], t1GatePin};
    if (cur_ff.pin0Sync[1] == cur_ff.pin0Sync[2])
      nxt_st.pin0Stable = cur_ff.pin0Sync[2];
    if (cur_ff.pin1Sync[1] == cur_ff.pin1Sync[2])
      nxt_st.pin1Stable = cur_ff.pin1Sync[2];
    fall0    = cur_ff.pin0Stable && (cur_ff.pin0Sync[1] == cur_ff.pin0Sync[2]) && !cur_ff.pin0Sync[2];
    fall1    = cur_ff.pin1Stable && (cur_ff.pin1Sync[1] == cur_ff.pin1Sync[2]) && !cur_ff.pin1Sync[2];
    // gate levels follow the same agreement rule, so a glitch cannot open the gate
    if (cur_ff.gate0Sync[1] == cur_ff.gate0Sync[2])
      nxt_st.gate0Stable = cur_ff.gate0Sync[2];
    if (cur_ff.gate1Sync[1] == cur_ff.gate1Sync[2])
      nxt_st.gate1Stable = cur_ff.gate1Sync[2];
    gate0Lvl = cur_ff.gate0Stable;
    gate1Lvl = cur_ff.gate1Stable;

    // free-running prescalers, one per timer
    divTick0 = (cur_ff.div0 >= divTop(cur_ff.prescale[BIT_T0_PRESCALE]));
    divTick1 = (cur_ff.div1 >= divTop(cur_ff.prescale[BIT_T1_PRESCALE]));
    nxt_st.div0 = divTick0 ? 4'h0 : cur_ff.div0 + 4'h1;
    nxt_st.div1 = divTick1 ? 4'h0 : cur_ff.div1 + 4'h1;

    // clock source: external falling edge or internal prescaled tick
    inc0 = cur_ff.mode[BIT_T0_COUNT_SEL] ? fall0 : divTick0;
    inc1 = cur_ff.mode[BIT_T1_COUNT_SEL] ? fall1 : divTick1;

    en0 = runGate(cur_ff.control[BIT_T0_RUN], cur_ff.mode[BIT_T0_GATE], gate0Lvl);
    en1 = runGate(cur_ff.control[BIT_T1_RUN], cur_ff.mode[BIT_T1_GATE], gate1Lvl);
    // split high byte: internal clock only, timer 1 run bit and gate
    incSplitHi = divTick0 && en1;
    // timer 1 in mode 3 simply holds, as a stopped timer
    t1Idle = (mode1 == 2'b11);

    ovf0 = 1'b0;
    ovf1 = 1'b0;
    sumLo = {1'b0, cur_ff.t0Low} + 9'h001;
    sumHi = {1'b0, cur_ff.t0High} + 9'h001;
    if (en0 && inc0)
    begin
      unique case (mode0)
        2'b00:
        begin
          nxt_st.t0Low = {3'h0, sumLo[4:0]};
          if (cur_ff.t0Low[4:0] == 5'h1F)
          begin
            nxt_st.t0High = sumHi[7:0];
            ovf0          = sumHi[8];
          end
        end
        2'b01:
        begin
          nxt_st.t0Low = sumLo[7:0];
          if (sumLo[8])
          begin
            nxt_st.t0High = sumHi[7:0];
            ovf0          = sumHi[8];
          end
        end
        2'b10:
        begin
          nxt_st.t0Low = sumLo[8] ? cur_ff.t0High : sumLo[7:0];
          ovf0         = sumLo[8];
        end
        2'b11:
        begin
          nxt_st.t0Low = sumLo[7:0];
          ovf0         = sumLo[8];
        end
      endcase
    end
    if ((mode0 == 2'b11) && incSplitHi)
    begin
      nxt_st.t0High = sumHi[7:0];
      ovf1          = sumHi[8];
    end

    sumLo1 = {1'b0, cur_ff.t1Low} + 9'h001;
    sumHi1 = {1'b0, cur_ff.t1High} + 9'h001;
    // with timer 0 split, timer 1 still counts but no longer owns its flag
    if (!t1Idle && inc1 && (mode0 == 2'b11 ? cur_ff.control[BIT_T1_RUN] : en1))
    begin
      unique case (mode1)
        2'b00:
        begin
          nxt_st.t1Low = {3'h0, sumLo1[4:0]};
          if (cur_ff.t1Low[4:0] == 5'h1F)
          begin
            nxt_st.t1High = sumHi1[7:0];
            nxt_t1Tick    = sumHi1[8];
          end
        end
        2'b01:
        begin
          nxt_st.t1Low = sumLo1[7:0];
          if (sumLo1[8])
          begin
            nxt_st.t1High = sumHi1[7:0];
            nxt_t1Tick    = sumHi1[8];
          end
        end
        2'b10:
        begin
          nxt_st.t1Low = sumLo1[8] ? cur_ff.t1High : sumLo1[7:0];
          nxt_t1Tick   = sumLo1[8];
        end
        2'b11:
        begin
          nxt_st.t1Low = cur_ff.t1Low;
        end
      endcase
    end
    if (mode0 != 2'b11)
      ovf1 = nxt_t1Tick;
    nxt_st.t1Tick = nxt_t1Tick;

    // bus: address phase latched, data phase acts one cycle later
    nxt_st.busPhase = DTCU_BUS_IDLE;
    if (addrPhase)
    begin
      nxt_st.busAddr  = haddr;
      nxt_st.busPhase = hwrite ? DTCU_BUS_WRITE : DTCU_BUS_READ;
    end
    if (cur_ff.busPhase == DTCU_BUS_WRITE)
    begin
      unique case (cur_ff.busAddr)
        ADDR_TIMER_CONTROL:  nxt_st.control  = wbyte;
        ADDR_TIMER_MODE:     nxt_st.mode     = wbyte;
        ADDR_TIMER0_LOW:     nxt_st.t0Low    = wbyte;
        ADDR_TIMER0_HIGH:    nxt_st.t0High   = wbyte;
        ADDR_TIMER1_LOW:     nxt_st.t1Low    = wbyte;
        ADDR_TIMER1_HIGH:    nxt_st.t1High   = wbyte;
        ADDR_PRESCALE_CTRL:  nxt_st.prescale = wbyte;
        ADDR_IRQ_CLEAR:      nxt_st.irqStatus = cur_ff.irqStatus & ~wbyte[1:0];
        ADDR_IRQ_ENABLE:     nxt_st.irqEnable = wbyte[1:0];
        ADDR_ISR_ENTRY:      isrEntry = wbyte[1:0];
        default:             ;
      endcase
    end
    // interrupt-entry acknowledge clears the flag by hardware
    if (isrEntry[0])
      nxt_st.control[BIT_T0_OVERFLOW] = 1'b0;
    if (isrEntry[1])
      nxt_st.control[BIT_T1_OVERFLOW] = 1'b0;
    // setting wins over any clear in the same cycle
    if (ovf0)
    begin
      nxt_st.control[BIT_T0_OVERFLOW] = 1'b1;
      nxt_st.irqStatus[0]             = 1'b1;
    end
    if (ovf1)
    begin
      nxt_st.control[BIT_T1_OVERFLOW] = 1'b1;
      nxt_st.irqStatus[1]             = 1'b1;
    end
    nxt_st.irq = |(nxt_st.irqStatus & nxt_st.irqEnable);

    nxt_st.rdata = 32'h0000_0000;
    if (addrPhase && !hwrite)
    begin
      unique case (haddr)
        ADDR_TIMER_CONTROL:  nxt_st.rdata = {24'h000000, nxt_st.control};
        ADDR_TIMER_MODE:     nxt_st.rdata = {24'h000000, nxt_st.mode};
        ADDR_TIMER0_LOW:     nxt_st.rdata = {24'h000000, nxt_st.t0Low};
        ADDR_TIMER0_HIGH:    nxt_st.rdata = {24'h000000, nxt_st.t0High};
        ADDR_TIMER1_LOW:     nxt_st.rdata = {24'h000000, nxt_st.t1Low};
        ADDR_TIMER1_HIGH:    nxt_st.rdata = {24'h000000, nxt_st.t1High};
        ADDR_PRESCALE_CTRL:  nxt_st.rdata = {24'h000000, nxt_st.prescale};
        ADDR_IRQ_STATUS:     nxt_st.rdata = {30'h00000000, nxt_st.irqStatus};
        ADDR_IRQ_ENABLE:     nxt_st.rdata = {30'h00000000, nxt_st.irqEnable};
        default:             nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_ff          <= '0;
      cur_ff.busPhase <= DTCU_BUS_IDLE;
      cur_ff.control  <= RST_TIMER_CONTROL;
      cur_ff.mode     <= RST_TIMER_MODE;
      cur_ff.t0Low    <= RST_TIMER_BYTE;
      cur_ff.t0High   <= RST_TIMER_BYTE;
      cur_ff.t1Low    <= RST_TIMER_BYTE;
      cur_ff.t1High   <= RST_TIMER_BYTE;
      cur_ff.prescale <= RST_PRESCALE_CTRL;
      cur_ff.pin0Sync <= 3'h7;
      cur_ff.pin1Sync <= 3'h7;
      cur_ff.pin0Stable <= 1'b1;
      cur_ff.pin1Stable <= 1'b1;
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  assign hrdata          = cur_ff.rdata;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign irq             = cur_ff.irq;
  assign t1OverflowPulse = cur_ff.t1Tick;
endmodule // dtcu_timer_unit
`default_nettype wire

// ===== tb/dtcu_timer_unit_checker.sv
// dtcu_timer_unit_checker: bus and interrupt properties at the timer unit ports.
// assumes one clock domain, reset_n asynchronous active low.
`timescale 1ns/1ps
`default_nettype none
module dtcu_timer_unit_checker
  import dtcu_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        t0CountPin,
  input wire logic        t1CountPin,
  input wire logic        t0GatePin,
  input wire logic        t1GatePin,
  input wire logic        irq,
  input wire logic        t1OverflowPulse
);
  logic take;
  logic wrEnable_ff;
  logic wrIrqCtl_ff;
  assign take = hsel & htrans[1] & hready;
  // data-phase markers of the only writes allowed to lower irq
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wrEnable_ff <= 1'b0;
      wrIrqCtl_ff <= 1'b0;
    end
    else
    begin
      wrEnable_ff <= take & hwrite & (haddr == ADDR_IRQ_ENABLE);
      wrIrqCtl_ff <= take & hwrite & (haddr == ADDR_IRQ_ENABLE || haddr == ADDR_IRQ_CLEAR);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence rdUnmapped;
    take && !hwrite && (haddr < ADDR_TIMER_CONTROL || haddr > ADDR_ISR_ENTRY || haddr == 12'h23C);
  endsequence
  sequence maskAll;
    wrEnable_ff && hwdata[1:0] == 2'h0;
  endsequence
  chk_ready_high: assert property (hreadyout == 1'b1)
    else $error("hreadyout low");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  chk_data_width: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  chk_data_idle: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
    else $error("hrdata outside read data phase");
  chk_unmapped_zero: assert property (rdUnmapped |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_pulse_gap: assert property (t1OverflowPulse |=> !t1OverflowPulse [*3])
    else $error("overflow pulse too long");
  chk_irq_masked: assert property (maskAll |-> ##[1:2] !irq)
    else $error("irq stays with enables clear");
  chk_irq_sticky: assert property ($fell(irq) |-> $past(wrIrqCtl_ff) || $past(wrIrqCtl_ff, 2))
    else $error("irq fell without clear or mask");
endmodule // dtcu_timer_unit_checker
bind dtcu_timer_unit dtcu_timer_unit_checker u_chk (
  .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
  .hresp(hresp), .t0CountPin(t0CountPin), .t1CountPin(t1CountPin), .t0GatePin(t0GatePin),
  .t1GatePin(t1GatePin), .irq(irq), .t1OverflowPulse(t1OverflowPulse));
`default_nettype wire

// ===== tb/dtcu_pin_model.sv
// dtcu_pin_model: the external count and gate pins of both timers.
// assumes clk is the block clock; pins move just after rising edges.
`timescale 1ns/1ps
`default_nettype none
module dtcu_pin_model
(
  input  wire logic clk,
  output logic      t0CountPin,
  output logic      t1CountPin,
  output logic      t0GatePin,
  output logic      t1GatePin
);
  // count pins idle high so only commanded falls count
  initial
  begin
    t0CountPin = 1'b1;
    t1CountPin = 1'b1;
    t0GatePin = 1'b0;
    t1GatePin = 1'b0;
  end
  // each level held 4 clocks, above the synchroniser minimum of 2
  task automatic pulses(input int which, input int n);
    repeat (n)
    begin
      repeat (4) @(posedge clk);
      if (which == 0) t0CountPin <= 1'b0; else t1CountPin <= 1'b0;
      repeat (4) @(posedge clk);
      if (which == 0) t0CountPin <= 1'b1; else t1CountPin <= 1'b1;
    end
  endtask
  task automatic gate(input int which, input logic lvl);
    @(posedge clk);
    if (which == 0) t0GatePin <= lvl; else t1GatePin <= lvl;
  endtask
endmodule // dtcu_pin_model
`default_nettype wire

// ===== tb/tb_top.sv
// tb_top: self-checking bench for the dual timer/counter unit.
// assumes pin model and checker compiled first; 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import dtcu_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        hsel;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic        t1OverflowPulse;
  wire  [3:0]  pin;
  int          n_errors;
  int          compares;
  dtcu_pin_model pins (.clk(clk), .t0CountPin(pin[0]), .t1CountPin(pin[1]), .t0GatePin(pin[2]),
    .t1GatePin(pin[3]));
  dtcu_timer_unit uut (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .t0CountPin(pin[0]), .t1CountPin(pin[1]),
    .t0GatePin(pin[2]), .t1GatePin(pin[3]), .irq(irq), .t1OverflowPulse(t1OverflowPulse));
  always #5 clk = ~clk;
  task automatic conclude();
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic waitReady();
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1)
    begin
      n_errors++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    waitReady();
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    check(r, exp);
  endtask
  task automatic irqIs(input logic exp);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, {31'h0, exp});
  endtask
  task automatic resetValues();
    for (int i = 0; i < 7; i++)
      rdc(ADDR_TIMER_CONTROL + 12'(4 * i), (i == 6) ? 32'hC7 : 32'h0);
    rdc(12'h23C, 32'h0);
  endtask
  task automatic timerRate(input logic [7:0] pre, input logic [31:0] exp);
    wr(ADDR_PRESCALE_CTRL, pre);
    wr(ADDR_TIMER_MODE, 8'h01);
    wr(ADDR_TIMER0_LOW, 8'h00);
    wr(ADDR_TIMER_CONTROL, 8'h10);
    // run and stop both land at data-phase ends: a 240-edge window
    repeat (238) @(posedge clk);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    rdc(ADDR_TIMER0_LOW, exp);
    repeat (40) @(posedge clk);
    rdc(ADDR_TIMER0_LOW, exp);
  endtask
  task automatic overflow13();
    logic [31:0] v;
    wr(ADDR_TIMER_MODE, 8'h00);
    wr(ADDR_TIMER0_HIGH, 8'hFF);
    wr(ADDR_TIMER0_LOW, 8'h1F);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    wr(ADDR_TIMER_CONTROL, 8'h10);
    repeat (8) @(posedge clk);
    rdc(ADDR_TIMER_CONTROL, 32'h30);
    rdc(ADDR_TIMER0_HIGH, 32'h0);
    bus(1'b0, ADDR_TIMER0_LOW, 8'h00, v);
    check(v >> 5, 32'h0);
    irqIs(1'b1);
    wr(ADDR_ISR_ENTRY, 8'h01);
    rdc(ADDR_TIMER_CONTROL, 32'h10);
    irqIs(1'b1);
    wr(ADDR_IRQ_ENABLE, 8'h00);
    irqIs(1'b0);
    wr(ADDR_IRQ_ENABLE, 8'h01);
    irqIs(1'b1);
    wr(ADDR_IRQ_CLEAR, 8'h01);
    irqIs(1'b0);
    rdc(ADDR_IRQ_STATUS, 32'h0);
    wr(ADDR_TIMER_CONTROL, 8'h00);
  endtask
  task automatic reload8();
    logic [31:0] v;
    int n;
    wr(ADDR_PRESCALE_CTRL, 8'hD7);
    wr(ADDR_TIMER_MODE, 8'h20);
    wr(ADDR_TIMER1_HIGH, 8'hF0);
    wr(ADDR_TIMER1_LOW, 8'hFE);
    wr(ADDR_TIMER_CONTROL, 8'h40);
    n = 0;
    while (t1OverflowPulse !== 1'b1 && n < 64)
    begin
      @(posedge clk);
      n++;
    end
    check({31'h0, t1OverflowPulse}, 32'h1);
    if (t1OverflowPulse !== 1'b1)
      conclude();
    rdc(ADDR_TIMER_CONTROL, 32'hC0);
    wr(ADDR_TIMER_CONTROL, 8'h00);
    bus(1'b0, ADDR_TIMER1_LOW, 8'h00, v);
    check(32'(v >= 32'hF0 && v <= 32'hF2), 32'h1);
    rdc(ADDR_TIMER1_HIGH, 32'hF0);
  endtask
  task automatic counter(input int which);
    logic [11:0] low;
    low = which ? ADDR_TIMER1_LOW : ADDR_TIMER0_LOW;
    wr(ADDR_TIMER_MODE, which ? 8'h50 : 8'h05);
    wr(low, 8'h00);
    wr(ADDR_TIMER_CONTROL, which ? 8'h40 : 8'h10);
    pins.pulses(which, 5);
    rdc(low, 32'h5);
    wr(ADDR_TIMER_MODE, which ? 8'hD0 : 8'h0D);
    pins.pulses(which, 3);
    rdc(low, 32'h5);
    pins.gate(which, 1'b1);
    pins.pulses(which, 2);
    rdc(low, 32'h7);
    pins.gate(which, 1'b0);
    wr(ADDR_TIMER_CONTROL, 8'h00);
  endtask
  task automatic split8();
    wr(ADDR_PRESCALE_CTRL, 8'hCF);
    wr(ADDR_TIMER_MODE, 8'h03);
    wr(ADDR_TIMER0_LOW, 8'h00);
    wr(ADDR_TIMER0_HIGH, 8'hFE);
    // timer 1 run drives the upper half; its own interrupt is not relied on
    wr(ADDR_TIMER_CONTROL, 8'h40);
    repeat (16) @(posedge clk);
    rdc(ADDR_TIMER_CONTROL, 32'hC0);
    rdc(ADDR_TIMER0_LOW, 32'h0);
    // low half alone on timer 0 run: only timer 0's flag may rise
    wr(ADDR_TIMER0_LOW, 8'hFE);
    wr(ADDR_TIMER_CONTROL, 8'h10);
    repeat (16) @(posedge clk);
    rdc(ADDR_TIMER_CONTROL, 32'h30);
    wr(ADDR_TIMER_CONTROL, 8'h00);
  endtask
  initial
  begin
    clk = 1'b0;
    reset_n = 1'b0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    n_errors = 0;
    compares = 0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    resetValues();
    timerRate(8'hC7, 32'h14);
    timerRate(8'hCF, 32'h3C);
    overflow13();
    reload8();
    counter(0);
    counter(1);
    split8();
    conclude();
  end
endmodule // tb_top
`default_nettype wire
